//--- logic/alsr_defines.svh
// Offsets, field positions, reset values and codes of the aux/status bank.
// Assumes byte-wide registers addressed by an 8-bit register index.
`ifndef ALSR_DEFINES_SVH
`define ALSR_DEFINES_SVH
`define ALSR_OFS_CLIP 8'h4a
`define ALSR_OFS_TGT 8'h4b
`define ALSR_OFS_CFG 8'h4c
`define ALSR_OFS_RDP 8'h4d
`define ALSR_OFS_WRP 8'h4e
`define ALSR_OFS_WRB 8'h4f
`define ALSR_OFS_MASK 8'h52
`define ALSR_OFS_MAP 8'h58
`define ALSR_RST_TGT 8'h20
`define ALSR_RST_CFG 8'h83
`define ALSR_RST_RDP 8'h42
`define ALSR_RST_WRP 8'h4c
`define ALSR_RST_WRB 8'h02
`define ALSR_RST_MASK 8'h00
`define ALSR_RST_MAP 8'h00
`define ALSR_WMASK_TGT 8'hfe
`define ALSR_WMASK_CFG 8'hcf
`define ALSR_WMASK_MASK 8'hdf
`define ALSR_WMASK_MAP 8'h88
`define ALSR_CFG_AUTO_BL 0
`define ALSR_CFG_MAN_BL 2
`define ALSR_CFG_TRIG_WR 6
`define ALSR_CFG_MANUAL 7
`define ALSR_MASK_FATAL 0
`define ALSR_MASK_INT_LSB 1
`define ALSR_MASK_FIFO 6
`define ALSR_MASK_AUX 7
`define ALSR_MAP_PIN_ONE 3
`define ALSR_MAP_PIN_TWO 7
`define ALSR_SAT_NEG 16'h8001
`define ALSR_SAT_POS 16'h7fff
`define ALSR_BL_CODE0 4'h1
`define ALSR_BL_CODE1 4'h2
`define ALSR_BL_CODE2 4'h6
`define ALSR_BL_CODE3 4'h8
`endif

//--- logic/alsr_pkg.sv
// Types shared by the aux/status bank modules.
// Assumes the constants header is included where figures are needed.
package alsr_pkg;

  // Phases of the auxiliary transfer sequencer.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WRITE,
    SEQ_READ
  } alsr_seq_state_t;

endpackage : alsr_pkg

//--- logic/alsr_clip_detect.sv
// Per-axis saturation detection for accelerometer and gyroscope.
// Assumes raw strobes and data-update strobes are one-cycle pulses.
`include "alsr_defines.svh"
module alsr_clip_detect (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic acc_raw_valid,
  input wire logic gyr_raw_valid,
  input wire logic [95:0] raw_samples,
  input wire logic acc_data_update,
  input wire logic gyr_data_update,
  output logic [5:0] clip_flags
);

  // One detector per axis; axes 0..2 are accel, 3..5 gyro.
  for (genvar i = 0; i < 6; i++) begin : g_axis
    logic hit;
    logic acc_ff;
    logic nxt_acc;
    logic flag_ff;
    logic nxt_flag;
    logic raw_v;
    logic upd;
    logic [15:0] smp;

    // Select the sample and the strobes belonging to this axis.
    always_comb begin
      smp = raw_samples[16*i +: 16];
      raw_v = (i < 3) ? acc_raw_valid : gyr_raw_valid;
      upd = (i < 3) ? acc_data_update : gyr_data_update;
      hit = raw_v && (smp == `ALSR_SAT_NEG || smp == `ALSR_SAT_POS);
    end

    // Collect hits over the filter window; publish with the data update.
    always_comb begin
      nxt_acc = upd ? 1'b0 : (acc_ff | hit);
      nxt_flag = upd ? (acc_ff | hit) : flag_ff;
    end

    // Flag and accumulator registers.
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        acc_ff <= 1'b0;
        flag_ff <= 1'b0;
      end else if (clk_en) begin
        acc_ff <= nxt_acc;
        flag_ff <= nxt_flag;
      end
    end

    assign clip_flags[i] = flag_ff;
  end

endmodule : alsr_clip_detect

//--- logic/alsr_aux_seq.sv
// Sequencer that launches transfers on the auxiliary I2C master.
// Assumes the master pulses aux_done once per launched transfer.
`include "alsr_defines.svh"
module alsr_aux_seq (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic manual_mode,
  input wire logic trig_write_en,
  input wire logic [1:0] auto_len_code,
  input wire logic [1:0] man_len_code,
  input wire logic [7:0] read_ptr,
  input wire logic [7:0] write_ptr,
  input wire logic [7:0] write_byte,
  input wire logic man_rd_req,
  input wire logic man_wr_req,
  input wire logic poll_tick,
  input wire logic aux_done,
  output logic aux_start,
  output logic aux_write,
  output logic [7:0] aux_reg_addr,
  output logic [7:0] aux_wdata,
  output logic [3:0] aux_burst_len,
  output logic aux_busy
);

  alsr_pkg::alsr_seq_state_t st_ff, nxt_st;
  logic pend_rd_ff, nxt_pend_rd, pend_wr_ff, nxt_pend_wr;
  logic pend_poll_ff, nxt_pend_poll, chain_ff, nxt_chain;
  logic start_ff, nxt_start, write_ff, nxt_write;
  logic [7:0] addr_ff, nxt_addr, wdata_ff, nxt_wdata;
  logic [3:0] len_ff, nxt_len;
  logic take_rd, take_wr, take_poll;

  // Maps a two-bit burst code onto its byte count.
  function automatic logic [3:0] burst_len(input logic [1:0] code);
    unique case (code)
      2'h0: burst_len = `ALSR_BL_CODE0;
      2'h1: burst_len = `ALSR_BL_CODE1;
      2'h2: burst_len = `ALSR_BL_CODE2;
      2'h3: burst_len = `ALSR_BL_CODE3;
    endcase
  endfunction : burst_len

  // Launch decisions; a new transfer starts from idle, or as the chained read when a trigger write completes.
  always_comb begin
    nxt_st = st_ff;
    nxt_chain = chain_ff;
    nxt_start = 1'b0;
    nxt_write = write_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_len = len_ff;
    take_rd = 1'b0;
    take_wr = 1'b0;
    take_poll = 1'b0;
    unique case (st_ff)
      alsr_pkg::SEQ_IDLE: begin
        if (pend_wr_ff) begin
          take_wr = 1'b1;
          nxt_st = alsr_pkg::SEQ_WRITE;
          nxt_chain = 1'b0;
        end else if (pend_rd_ff) begin
          take_rd = 1'b1;
          nxt_st = alsr_pkg::SEQ_READ;
          nxt_len = burst_len(man_len_code);
        end else if (pend_poll_ff) begin
          take_poll = 1'b1;
          nxt_chain = trig_write_en;
          nxt_st = trig_write_en ? alsr_pkg::SEQ_WRITE : alsr_pkg::SEQ_READ;
          nxt_len = burst_len(auto_len_code);
        end
        if (take_wr || take_rd || take_poll) begin
          nxt_start = 1'b1;
          nxt_write = (nxt_st == alsr_pkg::SEQ_WRITE);
          nxt_addr = nxt_write ? write_ptr : read_ptr;
          nxt_wdata = write_byte;
        end
      end
      alsr_pkg::SEQ_WRITE, alsr_pkg::SEQ_READ: begin
        if (aux_done && chain_ff) begin
          nxt_chain = 1'b0;
          nxt_st = alsr_pkg::SEQ_READ;
          nxt_start = 1'b1;
          nxt_write = 1'b0;
          nxt_addr = read_ptr;
          nxt_len = burst_len(auto_len_code);
        end else if (aux_done) begin
          nxt_st = alsr_pkg::SEQ_IDLE;
        end
      end
      default: nxt_st = alsr_pkg::SEQ_IDLE;
    endcase
    // Requests are held until taken, a poll only while manual mode is off; a new one beats the take.
    nxt_pend_rd = (man_rd_req && manual_mode) || (pend_rd_ff && !take_rd);
    nxt_pend_wr = (man_wr_req && manual_mode) || (pend_wr_ff && !take_wr);
    nxt_pend_poll = (poll_tick && !manual_mode) ||
                    (pend_poll_ff && !take_poll && !manual_mode);
  end

  // Sequencer registers.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= alsr_pkg::SEQ_IDLE;
      pend_rd_ff <= 1'b0;
      pend_wr_ff <= 1'b0;
      pend_poll_ff <= 1'b0;
      chain_ff <= 1'b0;
      start_ff <= 1'b0;
      write_ff <= 1'b0;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      len_ff <= 4'h0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
      pend_rd_ff <= nxt_pend_rd;
      pend_wr_ff <= nxt_pend_wr;
      pend_poll_ff <= nxt_pend_poll;
      chain_ff <= nxt_chain;
      start_ff <= nxt_start;
      write_ff <= nxt_write;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      len_ff <= nxt_len;
    end
  end

  assign aux_start = start_ff;
  assign aux_write = write_ff;
  assign aux_reg_addr = addr_ff;
  assign aux_wdata = wdata_ff;
  assign aux_burst_len = len_ff;
  assign aux_busy = (st_ff != alsr_pkg::SEQ_IDLE);

endmodule : alsr_aux_seq

//--- logic/alsr_regs.sv
// Auxiliary link, saturation status and error mask register bank.
// Assumes a single-cycle strobe register port and one clock domain.
`include "alsr_defines.svh"
module alsr_regs (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic acc_raw_valid,
  input wire logic gyr_raw_valid,
  input wire logic [95:0] raw_samples,
  input wire logic acc_data_update,
  input wire logic gyr_data_update,
  input wire logic fatal_err,
  input wire logic [3:0] internal_err,
  input wire logic fifo_err,
  input wire logic aux_err,
  output logic fault_irq,
  output logic fault_to_pin_one,
  output logic fault_to_pin_two,
  input wire logic poll_tick,
  input wire logic aux_done,
  output logic aux_start,
  output logic aux_write,
  output logic [6:0] aux_dev_addr,
  output logic [7:0] aux_reg_addr,
  output logic [7:0] aux_wdata,
  output logic [3:0] aux_burst_len,
  output logic aux_busy
);

  // Software-visible storage.
  logic [7:0] tgt_ff, nxt_tgt;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] rdp_ff, nxt_rdp;
  logic [7:0] wrp_ff, nxt_wrp;
  logic [7:0] wrb_ff, nxt_wrb;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] map_ff, nxt_map;
  logic [7:0] rdata_ff, nxt_rdata;

  // Error interrupt outputs.
  logic fault_ff, nxt_fault;
  logic pin_one_ff, nxt_pin_one;
  logic pin_two_ff, nxt_pin_two;

  // Decoded strobes and derived values.
  logic wr_tgt, wr_cfg, wr_rdp, wr_wrp, wr_wrb, wr_mask, wr_map;
  logic [5:0] clip_flags;
  logic [7:0] err_vec;
  logic [7:0] rd_mux;
  logic manual_mode;
  logic trig_write_en;

  // Address decode of the write strobe.
  always_comb begin
    wr_tgt = reg_wr && (reg_addr == `ALSR_OFS_TGT);
    wr_cfg = reg_wr && (reg_addr == `ALSR_OFS_CFG);
    wr_rdp = reg_wr && (reg_addr == `ALSR_OFS_RDP);
    wr_wrp = reg_wr && (reg_addr == `ALSR_OFS_WRP);
    wr_wrb = reg_wr && (reg_addr == `ALSR_OFS_WRB);
    wr_mask = reg_wr && (reg_addr == `ALSR_OFS_MASK);
    wr_map = reg_wr && (reg_addr == `ALSR_OFS_MAP);
  end

  // Target address next value; bit 0 is reserved and stays clear.
  always_comb begin
    nxt_tgt = tgt_ff;
    if (wr_tgt) begin
      nxt_tgt = reg_wdata & `ALSR_WMASK_TGT;
    end
  end

  // Target address storage.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tgt_ff <= `ALSR_RST_TGT;
    end else if (clk_en) begin
      tgt_ff <= nxt_tgt;
    end
  end

  // Link configuration next value; bits 5:4 are reserved.
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_cfg) begin
      nxt_cfg = reg_wdata & `ALSR_WMASK_CFG;
    end
  end

  // Link configuration storage; it wakes up in manual mode.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff <= `ALSR_RST_CFG;
    end else if (clk_en) begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Read pointer next value; in manual mode the same write is also a read trigger.
  always_comb begin
    nxt_rdp = rdp_ff;
    if (wr_rdp) begin
      nxt_rdp = reg_wdata;
    end
  end

  // Read pointer storage.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdp_ff <= `ALSR_RST_RDP;
    end else if (clk_en) begin
      rdp_ff <= nxt_rdp;
    end
  end

  // Write pointer next value; in manual mode the same write is also a write trigger.
  always_comb begin
    nxt_wrp = wrp_ff;
    if (wr_wrp) begin
      nxt_wrp = reg_wdata;
    end
  end

  // Write pointer storage.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrp_ff <= `ALSR_RST_WRP;
    end else if (clk_en) begin
      wrp_ff <= nxt_wrp;
    end
  end

  // Write byte next value; it is sent by the next write transfer.
  always_comb begin
    nxt_wrb = wrb_ff;
    if (wr_wrb) begin
      nxt_wrb = reg_wdata;
    end
  end

  // Write byte storage.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrb_ff <= `ALSR_RST_WRB;
    end else if (clk_en) begin
      wrb_ff <= nxt_wrb;
    end
  end

  // Error mask next value; bit 5 is reserved.
  always_comb begin
    nxt_mask = mask_ff;
    if (wr_mask) begin
      nxt_mask = reg_wdata & `ALSR_WMASK_MASK;
    end
  end

  // Error mask storage; all errors are blocked after reset.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_ff <= `ALSR_RST_MASK;
    end else if (clk_en) begin
      mask_ff <= nxt_mask;
    end
  end

  // Error routing next value; only the two pin bits are kept.
  always_comb begin
    nxt_map = map_ff;
    if (wr_map) begin
      nxt_map = reg_wdata & `ALSR_WMASK_MAP;
    end
  end

  // Error routing storage; no pin is driven after reset.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      map_ff <= `ALSR_RST_MAP;
    end else if (clk_en) begin
      map_ff <= nxt_map;
    end
  end

  // Read multiplexer; unmapped offsets answer zero.
  always_comb begin
    unique case (reg_addr)
      `ALSR_OFS_CLIP: rd_mux = {2'b00, clip_flags};
      `ALSR_OFS_TGT: rd_mux = tgt_ff;
      `ALSR_OFS_CFG: rd_mux = cfg_ff;
      `ALSR_OFS_RDP: rd_mux = rdp_ff;
      `ALSR_OFS_WRP: rd_mux = wrp_ff;
      `ALSR_OFS_WRB: rd_mux = wrb_ff;
      `ALSR_OFS_MASK: rd_mux = mask_ff;
      `ALSR_OFS_MAP: rd_mux = map_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_comb begin
    nxt_rdata = reg_rd ? rd_mux : 8'h00;
  end

  // Read data register.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else if (clk_en) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // Error flags laid out like the mask so one AND gates them.
  always_comb begin
    err_vec = 8'h00;
    err_vec[`ALSR_MASK_FATAL] = fatal_err;
    err_vec[`ALSR_MASK_INT_LSB +: 4] = internal_err;
    err_vec[`ALSR_MASK_FIFO] = fifo_err;
    err_vec[`ALSR_MASK_AUX] = aux_err;
  end

  // Combined error interrupt and its per-pin routing.
  always_comb begin
    nxt_fault = |(err_vec & mask_ff);
    nxt_pin_one = nxt_fault && map_ff[`ALSR_MAP_PIN_ONE];
    nxt_pin_two = nxt_fault && map_ff[`ALSR_MAP_PIN_TWO];
  end

  // Interrupt output registers.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_ff <= 1'b0;
      pin_one_ff <= 1'b0;
      pin_two_ff <= 1'b0;
    end else if (clk_en) begin
      fault_ff <= nxt_fault;
      pin_one_ff <= nxt_pin_one;
      pin_two_ff <= nxt_pin_two;
    end
  end

  assign fault_irq = fault_ff;
  assign fault_to_pin_one = pin_one_ff;
  assign fault_to_pin_two = pin_two_ff;

  // Configuration fields steering the sequencer.
  assign manual_mode = cfg_ff[`ALSR_CFG_MANUAL];
  assign trig_write_en = cfg_ff[`ALSR_CFG_TRIG_WR];
  assign aux_dev_addr = tgt_ff[7:1];

  // Saturation detectors for all six axes.
  alsr_clip_detect u_clip (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .acc_raw_valid(acc_raw_valid),
    .gyr_raw_valid(gyr_raw_valid),
    .raw_samples(raw_samples),
    .acc_data_update(acc_data_update),
    .gyr_data_update(gyr_data_update),
    .clip_flags(clip_flags)
  );

  // Auxiliary transfer sequencer; pointer writes act as triggers in manual mode.
  alsr_aux_seq u_seq (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .manual_mode(manual_mode),
    .trig_write_en(trig_write_en),
    .auto_len_code(cfg_ff[`ALSR_CFG_AUTO_BL +: 2]),
    .man_len_code(cfg_ff[`ALSR_CFG_MAN_BL +: 2]),
    .read_ptr(nxt_rdp),
    .write_ptr(nxt_wrp),
    .write_byte(nxt_wrb),
    .man_rd_req(wr_rdp),
    .man_wr_req(wr_wrp),
    .poll_tick(poll_tick),
    .aux_done(aux_done),
    .aux_start(aux_start),
    .aux_write(aux_write),
    .aux_reg_addr(aux_reg_addr),
    .aux_wdata(aux_wdata),
    .aux_burst_len(aux_burst_len),
    .aux_busy(aux_busy)
  );

endmodule : alsr_regs

//--- dv/alsr_regs_props.sv
// Port-level checker for the aux/status register bank.
// Assumes clk_en is only lowered while the link is idle.
module alsr_regs_props (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic fault_irq,
  input wire logic fault_to_pin_one,
  input wire logic fault_to_pin_two,
  input wire logic aux_start,
  input wire logic aux_write,
  input wire logic [3:0] aux_burst_len,
  input wire logic aux_done,
  input wire logic aux_busy,
  input wire logic [6:0] aux_dev_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // A launch opens a busy span and does not repeat at once.
  sequence s_held;
    aux_busy ##1 (aux_busy && !aux_start);
  endsequence
  property p_launch;
    aux_start |-> s_held;
  endproperty
  a_launch: assert property (p_launch)
    else $error("launch not followed by busy");
  property p_no_overlap;
    aux_start |-> !$past(aux_busy) || $past(aux_done);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("launch while a transfer runs");
  property p_done_end;
    aux_done |=> !aux_busy || aux_start;
  endproperty
  a_done_end: assert property (p_done_end)
    else $error("busy outlives done");
  property p_len;
    aux_start && !aux_write |-> aux_burst_len inside {4'h1, 4'h2, 4'h6, 4'h8};
  endproperty
  a_len: assert property (p_len)
    else $error("illegal burst length");
  property p_fields_hold;
    aux_busy && !aux_start |-> $stable(aux_burst_len) && $stable(aux_write);
  endproperty
  a_fields_hold: assert property (p_fields_hold)
    else $error("transfer fields moved mid transfer");
  property p_pin_one;
    fault_to_pin_one |-> fault_irq;
  endproperty
  a_pin_one: assert property (p_pin_one)
    else $error("pin one fault without fault");
  property p_pin_two;
    fault_to_pin_two |-> fault_irq;
  endproperty
  a_pin_two: assert property (p_pin_two)
    else $error("pin two fault without fault");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_dev_rst;
    $rose(arst_n) |-> aux_dev_addr == 7'h10;
  endproperty
  a_dev_rst: assert property (p_dev_rst)
    else $error("target address not at reset value");
endmodule : alsr_regs_props

//--- dv/alsr_aux_peer.sv
// Model of the aux link master that answers each launched transfer.
// Assumes launches never overlap; slow picks a long answer.
module alsr_aux_peer (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic aux_start,
  output logic aux_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_ff;

  // Each launch is finished once, after one cycle or after nine.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 4'h0;
    end else if (aux_start) begin
      cnt_ff <= slow ? 4'h9 : 4'h1;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
  assign aux_done = (cnt_ff == 4'h1);
endmodule : alsr_aux_peer

//--- dv/alsr_regs_tb.sv
// Self-checking bench for the aux/status register bank.
// Assumes the peer model finishes every launched transfer.
module alsr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, arst_n, clk_en, reg_wr, reg_rd, acc_raw_valid;
  logic gyr_raw_valid, acc_data_update, gyr_data_update, poll_tick;
  logic slow, fault_irq, fault_to_pin_one, fault_to_pin_two, aux_done;
  logic aux_start, aux_write, aux_busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, err_v, aux_reg_addr, aux_wdata;
  logic [7:0] v, d, m, e, mp, x;
  logic [95:0] raw_samples, rv;
  logic [6:0] aux_dev_addr;
  logic [3:0] aux_burst_len;
  logic [5:0] flags;
  logic [7:0] adr [9] = '{8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h52,
    8'h58, 8'h50};
  logic [7:0] rst [9] = '{8'h00, 8'h20, 8'h83, 8'h42, 8'h4c, 8'h02, 8'h00,
    8'h00, 8'h00};
  int errors, tests_run;

  alsr_regs dut_u (.sys_clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .acc_raw_valid, .gyr_raw_valid, .raw_samples,
    .acc_data_update, .gyr_data_update, .fatal_err(err_v[0]),
    .internal_err(err_v[4:1]), .fifo_err(err_v[6]), .aux_err(err_v[7]),
    .fault_irq, .fault_to_pin_one, .fault_to_pin_two, .poll_tick, .aux_done,
    .aux_start, .aux_write, .aux_dev_addr, .aux_reg_addr, .aux_wdata,
    .aux_burst_len, .aux_busy);
  alsr_aux_peer peer_u (.sys_clk, .arst_n, .slow, .aux_start, .aux_done);

  // Bits that read back after a write; zero where read-only or unmapped.
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h4b: return 8'hfe;
      8'h4c: return 8'hcf;
      8'h52: return 8'hdf;
      8'h58: return 8'h88;
      8'h4d, 8'h4e, 8'h4f: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction : wmask

  // Bytes fetched for each burst length code.
  function automatic logic [3:0] blen(input logic [1:0] c);
    case (c)
      2'h0: return 4'h1;
      2'h1: return 4'h2;
      2'h2: return 4'h6;
      default: return 4'h8;
    endcase
  endfunction : blen

  // Compares and counts; a difference is reported at once.
  task automatic chk(input string n, input logic [15:0] s,
    input logic [15:0] ex);
    tests_run++;
    if (s !== ex) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, ex, s);
    end
  endtask : chk

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle register read; data are checked in the following cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, ex);
  endtask : rd

  // Waits a bounded time for a launch, then checks what it carries.
  task automatic launch(input logic w, input logic [7:0] a,
    input logic [7:0] ex);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (!aux_start && k < 40);
    chk("aux_start", aux_start, 1'b1);
    chk("aux_write", aux_write, w);
    chk("aux_reg_addr", aux_reg_addr, a);
    chk(w ? "aux_wdata" : "aux_burst_len", w ? aux_wdata : aux_burst_len, ex);
  endtask : launch

  // Waits a bounded time for the link to fall idle.
  task automatic idle();
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (aux_busy && k < 40);
  endtask : idle

  // Drives the poll tick with t for one cycle, then expects no launch for ten cycles.
  task automatic quiet(input logic t);
    poll_tick <= t;
    @(posedge sys_clk);
    poll_tick <= 1'b0;
    repeat (10) begin
      @(posedge sys_clk);
      #1;
      chk("aux_start", aux_start, 1'b0);
    end
  endtask : quiet

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // Free-running clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Watchdog far beyond the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    conclude();
  end

  // Main sequence.
  initial begin
    {arst_n, reg_wr, reg_rd, acc_raw_valid, gyr_raw_valid} = 5'h0;
    {acc_data_update, gyr_data_update, poll_tick, slow} = 4'h0;
    {clk_en, reg_addr, reg_wdata, err_v, raw_samples} = {1'b1, 120'h0};
    errors = 0;
    tests_run = 0;
    void'($urandom(85985));
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    chk("aux_dev_addr", aux_dev_addr, 7'h10);
    foreach (adr[i]) rd(adr[i], rst[i]);
    foreach (adr[i]) begin
      d = $urandom;
      wr(adr[i], d);
      rd(adr[i], d & wmask(adr[i]));
      if (adr[i] == 8'h4b) chk("aux_dev_addr", aux_dev_addr, d[7:1]);
    end
    repeat (60) @(posedge sys_clk);
    // A write while the clock enable is low must leave no trace.
    wr(8'h4f, 8'h5a);
    clk_en <= 1'b0;
    wr(8'h4f, 8'ha5);
    clk_en <= 1'b1;
    rd(8'h4f, 8'h5a);
    // Saturation: one hit per axis, seen only after its group updates.
    flags = 6'h00;
    for (int i = 0; i < 6; i++) begin
      rv = {$urandom, $urandom, $urandom} & {6{16'h3fff}};
      rv[16*i+:16] = i[0] ? 16'h8001 : 16'h7fff;
      raw_samples <= rv;
      acc_raw_valid <= (i < 3);
      gyr_raw_valid <= (i >= 3);
      @(posedge sys_clk);
      acc_raw_valid <= 1'b0;
      gyr_raw_valid <= 1'b0;
      rd(8'h4a, {2'h0, flags});
      acc_data_update <= (i < 3);
      gyr_data_update <= (i >= 3);
      @(posedge sys_clk);
      {acc_data_update, gyr_data_update} <= 2'h0;
      flags = (i < 3) ? {flags[5:3], 3'h0} : {3'h0, flags[2:0]};
      flags[i] = 1'b1;
      rd(8'h4a, {2'h0, flags});
    end
    {acc_data_update, gyr_data_update} <= 2'h3;
    @(posedge sys_clk);
    {acc_data_update, gyr_data_update} <= 2'h0;
    rd(8'h4a, 8'h00);
    // Error mask: blocked bits, walking single bits, then random.
    for (int i = 0; i < 24; i++) begin
      e = $urandom;
      m = $urandom;
      mp = $urandom;
      if (i < 8) m = ~(8'h01 << i);
      if (i < 8) e = 8'h01 << i;
      if (i >= 8 && i < 16) m = 8'h01 << (i - 8);
      if (i >= 8 && i < 16) e = m;
      wr(8'h52, m);
      wr(8'h58, mp);
      err_v <= e;
      repeat (2) @(posedge sys_clk);
      #1;
      x = {7'h0, |(e & m & 8'hdf)};
      chk("fault_irq", fault_irq, x);
      chk("fault_to_pin_one", fault_to_pin_one, x & mp[3]);
      chk("fault_to_pin_two", fault_to_pin_two, x & mp[7]);
    end
    // Manual mode: host-triggered reads and writes only.
    for (int c = 0; c < 4; c++) begin
      slow <= c[0];
      wr(8'h4c, {4'h8, c[1:0], 2'h0});
      v = $urandom;
      wr(8'h4d, v);
      launch(1'b0, v, {4'h0, blen(c[1:0])});
      idle();
      quiet(1'b1);
      d = $urandom;
      wr(8'h4f, d);
      wr(8'h4e, v);
      launch(1'b1, v, d);
      idle();
    end
    // Automatic mode: polls, with a trigger write first when enabled.
    for (int c = 0; c < 4; c++) begin
      slow <= c[1];
      wr(8'h4c, {1'b0, c[0], 4'h0, c[1:0]});
      quiet(1'b0);
      poll_tick <= 1'b1;
      @(posedge sys_clk);
      poll_tick <= 1'b0;
      if (c[0]) launch(1'b1, v, d);
      launch(1'b0, v, {4'h0, blen(c[1:0])});
      idle();
    end
    wr(8'h4d, v);
    quiet(1'b0);
    conclude();
  end
endmodule : alsr_regs_tb

bind alsr_regs alsr_regs_props props_u (.sys_clk, .arst_n, .reg_rd, .reg_rdata,
  .fault_irq, .fault_to_pin_one, .fault_to_pin_two, .aux_start, .aux_write,
  .aux_burst_len, .aux_done, .aux_busy, .aux_dev_addr);
